// ### inc/event_aggregator_pkg.sv
// Constants, register map and carrier types of the event aggregator.
// Assumes one 10 MHz system clock and an AHB-Lite register port.
`default_nettype none

package event_aggregator_pkg;

    // Peripheral slots and flag widths.
    localparam int NUM_PERIPH  = 5;
    localparam int FLAG_W      = 15;
    localparam int NUM_LINES   = 17;
    localparam int P_TIMER1    = 0;
    localparam int P_TIMER2    = 1;
    localparam int P_SERIAL1   = 2;
    localparam int P_SERIAL2   = 3;
    localparam int P_CONVERTER = 4;

    // Top-level line driven by each peripheral slot.
    localparam int LINE_OF [NUM_PERIPH] = '{0, 1, 5, 6, 11};

    // Implemented flag bits of each peripheral slot.
    localparam logic [FLAG_W-1:0] VALID_MASK [NUM_PERIPH] =
        '{15'h005F, 15'h005F, 15'h7FFF, 15'h1FFF, 15'h001F};

    // Field positions inside the flag registers.
    localparam int TIMER_UPDATE_BIT   = 0;
    localparam int TIMER_CH1_BIT      = 1;
    localparam int TIMER_CH4_BIT      = 4;
    localparam int TIMER_TRIGGER_BIT  = 6;
    localparam int CONV_SAMPLE_BIT    = 0;
    localparam int CONV_HALF_BIT      = 1;
    localparam int CONV_FULL_BIT      = 2;
    localparam int CONV_SAT_BIT       = 3;
    localparam int CONV_OVERFLOW_BIT  = 4;
    localparam int SERIAL_FRAMING_BIT = 13;
    localparam int SERIAL_PARITY_BIT  = 14;

    // Register byte offsets (low eight address bits).
    localparam logic [7:0] FLAG_BASE    = 8'h00;
    localparam logic [7:0] ENABLE_BASE  = 8'h20;
    localparam logic [7:0] MISSED_OFS   = 8'h40;
    localparam logic [7:0] FAULT_OFS    = 8'h44;
    localparam logic [7:0] WDOG_OFS     = 8'h48;
    localparam logic [7:0] CLOCK_OFS    = 8'h4C;
    localparam logic [7:0] NMI_OFS      = 8'h50;

    // Bit positions of the single registers.
    localparam int FAULT_WIDTH_BIT  = 0;
    localparam int FAULT_PROT_BIT   = 1;
    localparam int FAULT_UNMAP_BIT  = 2;
    localparam int FAULT_REPEAT_BIT = 3;
    localparam int WDOG_EN_BIT      = 0;
    localparam int WDOG_RESTART_BIT = 1;
    localparam int CLK_CRYSTAL_BIT  = 0;
    localparam int NMI_CRYSTAL_BIT  = 0;
    localparam int NMI_WDOG_BIT     = 1;

    // Reset values.
    localparam logic [FLAG_W-1:0]    FLAG_RESET   = 15'h0000;
    localparam logic [NUM_LINES-1:0] MISSED_RESET = 17'h0_0000;
    localparam logic [3:0]           FAULT_RESET  = 4'h0;
    localparam logic [1:0]           NMI_RESET    = 2'h0;

    // Watchdog low-water time and its cycle count at the system clock.
    localparam longint WDOG_TIME_NS  = 64'd1792000000;
    localparam longint CLK_PERIOD_NS = 64'd100;
    localparam longint WDOG_CYCLES   = WDOG_TIME_NS / CLK_PERIOD_NS;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'b01,
        SRC_RC      = 2'b10
    } clock_source_t;

    // One-cycle event pulses from the peripherals.
    typedef struct packed {
        logic [14:0] serial1;
        logic [12:0] serial2;
        logic [6:0]  timer1;
        logic [6:0]  timer2;
        logic [4:0]  converter;
    } periph_events_t;

    // One observed system bus access, valid for one cycle.
    typedef struct packed {
        logic       valid;
        logic       is_apb;
        logic       write;
        logic       privileged;
        logic       protected_target;
        logic       beyond_map;
        logic [2:0] size;
        logic [1:0] addr_lo;
    } access_probe_t;

endpackage

`default_nettype wire

// ### rtl/event_aggregator.sv
// Second-level event aggregator with AHB-Lite register port.
// Assumes event pulses and access probes on hclk; crystal_lost is a pin.
//
// What this block does
// - Enable bit write one enables, zero disables.
// - Enable masks flag onto its top line.
// - Flag write one clears, zero ignored.
// - Events set flags regardless of enable.
// - Enabling an already set flag raises line.
// - Top line is level while enabled flag set.
// - Top line holds until all enabled flags cleared.
// - Event during clear keeps flag set.
// - Repeated enabled event sets missed bit.
// - Missed bit write one clears, zero ignored.
// - Converter flags drive line 11, five bits.
// - Serial flags drive lines 5 and 6.
// - Timer flags drive lines 0 and 1.
// - NMI from crystal failure and watchdog only.
// - Crystal failure switches to RC, raises NMI.
// - Unrestarted watchdog after 1.792 s raises NMI.
// - Bus fault causes recorded as status bits.
// - Wrong-size fault for narrow or unaligned APB access.
// - Protection fault for unprivileged protected writes.
// - Unmapped fault above last register or memory.
// - Second fault sets the repeat bit.
// - Each peripheral's events ORed into its own line.
// - One missed bit per top-level line.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`default_nettype none

module event_aggregator
    import event_aggregator_pkg::*;
#(
    parameter int unsigned WDOG_LIMIT = 32'(WDOG_CYCLES)
) (
    input  wire logic                 hclk,                // System clock.
    input  wire logic                 hresetn,             // Async reset.
    input  wire logic                 hsel,                // Slave select.
    input  wire logic [31:0]          haddr,               // Address.
    input  wire logic [1:0]           htrans,              // Transfer type.
    input  wire logic                 hwrite,              // Write access.
    input  wire logic [2:0]           hsize,               // Access size.
    input  wire logic [31:0]          hwdata,              // Write data.
    input  wire logic                 hready,              // Bus ready.
    output logic                      hreadyout,           // Slave ready.
    output logic [31:0]               hrdata,              // Read data.
    output logic                      hresp,               // Response.
    input  wire periph_events_t       periph_events,       // Event pulses.
    input  wire logic                 crystal_lost,        // Crystal pin.
    input  wire access_probe_t        access_probe,        // Bus access.
    output logic [NUM_LINES-1:0]      top_irq,             // Level lines.
    output logic                      nmi,                 // Non-maskable.
    output logic                      bus_fault,           // Fault pulse.
    output logic                      system_clock_source  // 1: crystal.
);

    generate
        if (WDOG_LIMIT < 2) begin : g_bad_limit
            $error("WDOG_LIMIT must be at least two cycles");
        end
    endgenerate

    function automatic logic [7:0] slot(input logic [7:0] base,
                                        input int         idx);
        return base + 8'(idx * 4);
    endfunction

    logic [FLAG_W-1:0]    flag         [NUM_PERIPH];
    logic [FLAG_W-1:0]    enable       [NUM_PERIPH];
    logic [FLAG_W-1:0]    next_flag    [NUM_PERIPH];
    logic [FLAG_W-1:0]    next_enable  [NUM_PERIPH];
    logic [FLAG_W-1:0]    ev           [NUM_PERIPH];
    logic [FLAG_W-1:0]    clr          [NUM_PERIPH];
    logic [NUM_LINES-1:0] missed;
    logic [NUM_LINES-1:0] next_missed;
    logic [NUM_LINES-1:0] next_line;
    logic [NUM_LINES-1:0] lost;
    logic [3:0]           fault;
    logic [3:0]           next_fault;
    logic [3:0]           new_fault;
    logic [1:0]           nmi_flags;
    logic [1:0]           next_nmi;
    logic                 wr_pending;
    logic [7:0]           wr_addr;
    logic [31:0]          rd_word;
    logic                 addr_phase;
    logic                 lost_meta;
    logic                 lost_sync;
    clock_source_t        clk_src;
    logic                 crystal_fail_evt;
    logic                 wdog_en;
    logic [31:0]          wdog_count;
    logic                 wdog_hit;
    logic                 wdog_restart;

    function automatic logic wr_to(input logic [7:0] ofs);
        return wr_pending && (wr_addr == ofs);
    endfunction

    // Bus slave: address phase captured, write applied in the data phase.
    assign addr_phase = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
        end else begin
            wr_pending <= addr_phase && hwrite;
            wr_addr    <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_phase && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        for (int p = 0; p < NUM_PERIPH; p++) begin
            if (haddr[7:0] == slot(FLAG_BASE, p)) begin
                rd_word = 32'(flag[p]);
            end else if (haddr[7:0] == slot(ENABLE_BASE, p)) begin
                rd_word = 32'(enable[p]);
            end
        end
        if (haddr[7:0] == MISSED_OFS) begin
            rd_word = 32'(missed);
        end else if (haddr[7:0] == FAULT_OFS) begin
            rd_word = 32'(fault);
        end else if (haddr[7:0] == WDOG_OFS) begin
            rd_word = 32'(wdog_en);
        end else if (haddr[7:0] == CLOCK_OFS) begin
            rd_word = 32'(clk_src == SRC_CRYSTAL);
        end else if (haddr[7:0] == NMI_OFS) begin
            rd_word = 32'(nmi_flags);
        end
    end

    // Event mapping onto peripheral slots.
    always_comb begin
        ev[P_TIMER1]    = 15'(periph_events.timer1);
        ev[P_TIMER2]    = 15'(periph_events.timer2);
        ev[P_SERIAL1]   = periph_events.serial1;
        ev[P_SERIAL2]   = 15'(periph_events.serial2);
        ev[P_CONVERTER] = 15'(periph_events.converter);
    end

    // Flag, enable and line combination.
    always_comb begin
        next_line = '0;
        lost      = '0;
        for (int p = 0; p < NUM_PERIPH; p++) begin
            clr[p] = wr_to(slot(FLAG_BASE, p)) ? hwdata[FLAG_W-1:0]
                                               : '0;
            // A new event beats a clear of the same bit.
            next_flag[p] = ((flag[p] & ~clr[p]) | ev[p])
                           & VALID_MASK[p];
            next_enable[p] = wr_to(slot(ENABLE_BASE, p))
                           ? hwdata[FLAG_W-1:0] & VALID_MASK[p]
                           : enable[p];
            next_line[LINE_OF[p]] =
                |(next_flag[p] & next_enable[p]);
            lost[LINE_OF[p]] =
                |(ev[p] & flag[p] & enable[p] & ~clr[p]);
        end
        next_missed = (missed & ~(wr_to(MISSED_OFS)
                                  ? hwdata[NUM_LINES-1:0] : '0))
                    | lost;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < NUM_PERIPH; p++) begin
                flag[p]   <= FLAG_RESET;
                enable[p] <= FLAG_RESET;
            end
            missed  <= MISSED_RESET;
            top_irq <= '0;
        end else begin
            for (int p = 0; p < NUM_PERIPH; p++) begin
                flag[p]   <= next_flag[p];
                enable[p] <= next_enable[p];
            end
            missed  <= next_missed;
            top_irq <= next_line;
        end
    end

    // Crystal monitor: two-stage synchroniser, then fall back to RC.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lost_meta <= 1'b0;
            lost_sync <= 1'b0;
        end else begin
            lost_meta <= crystal_lost;
            lost_sync <= lost_meta;
        end
    end

    assign crystal_fail_evt = (clk_src == SRC_CRYSTAL) && lost_sync;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_src             <= SRC_CRYSTAL;
            system_clock_source <= 1'b1;
        end else begin
            if (crystal_fail_evt) begin
                clk_src             <= SRC_RC;
                system_clock_source <= 1'b0;
            end else if (wr_to(CLOCK_OFS) && hwdata[CLK_CRYSTAL_BIT]
                         && !lost_sync) begin
                clk_src             <= SRC_CRYSTAL;
                system_clock_source <= 1'b1;
            end
        end
    end

    // Watchdog low-water counter.
    // Written out in full so that the assignment follows every operand.
    assign wdog_restart = wr_pending && (wr_addr == WDOG_OFS)
                       && hwdata[WDOG_RESTART_BIT];
    assign wdog_hit     = wdog_en && (wdog_count == WDOG_LIMIT - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_en    <= 1'b0;
            wdog_count <= 32'h0000_0000;
        end else begin
            if (wr_to(WDOG_OFS)) begin
                wdog_en <= hwdata[WDOG_EN_BIT];
            end
            if (!wdog_en || wdog_restart || wdog_hit) begin
                wdog_count <= 32'h0000_0000;
            end else begin
                wdog_count <= wdog_count + 32'h0000_0001;
            end
        end
    end

    // Non-maskable sources, sticky until written one.
    always_comb begin
        next_nmi = nmi_flags & ~(wr_to(NMI_OFS) ? hwdata[1:0] : 2'h0);
        next_nmi[NMI_CRYSTAL_BIT] = next_nmi[NMI_CRYSTAL_BIT]
                                  | crystal_fail_evt;
        next_nmi[NMI_WDOG_BIT]    = next_nmi[NMI_WDOG_BIT] | wdog_hit;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_flags <= NMI_RESET;
            nmi       <= 1'b0;
        end else begin
            nmi_flags <= next_nmi;
            nmi       <= |next_nmi;
        end
    end

    // Bus fault causes.
    always_comb begin
        new_fault = 4'h0;
        if (access_probe.valid) begin
            new_fault[FAULT_WIDTH_BIT] = access_probe.is_apb
                && ((access_probe.size != HSIZE_WORD)
                    || (access_probe.addr_lo != 2'h0));
            new_fault[FAULT_PROT_BIT] = access_probe.write
                && !access_probe.privileged
                && access_probe.protected_target;
            new_fault[FAULT_UNMAP_BIT] = access_probe.beyond_map;
            new_fault[FAULT_REPEAT_BIT] = (|new_fault[2:0])
                && (|fault[2:0]);
        end
        next_fault = (fault & ~(wr_to(FAULT_OFS) ? hwdata[3:0] : 4'h0))
                   | new_fault;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault     <= FAULT_RESET;
            bus_fault <= 1'b0;
        end else begin
            fault     <= next_fault;
            bus_fault <= |new_fault[2:0];
        end
    end

    // Checks.
    logic [FLAG_W-1:0] conv_clr;
    assign conv_clr = clr[P_CONVERTER];

    enable_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pending && wr_addr == slot(ENABLE_BASE, P_TIMER1)
        |=> enable[P_TIMER1] == ($past(hwdata[FLAG_W-1:0]) & 15'h005F))
        else $error("enable register did not take written value");

    event_sets_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        |periph_events.converter
        |=> (flag[P_CONVERTER][4:0] & $past(periph_events.converter))
            == $past(periph_events.converter))
        else $error("converter event did not set its flag");

    flag_clear_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (|conv_clr) && !(|periph_events.converter)
        |=> (flag[P_CONVERTER] & $past(conv_clr)) == '0)
        else $error("write one did not clear converter flag");

    set_wins_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        conv_clr[CONV_OVERFLOW_BIT]
        && periph_events.converter[CONV_OVERFLOW_BIT]
        |=> flag[P_CONVERTER][CONV_OVERFLOW_BIT])
        else $error("event lost during clear");

    line_level_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        top_irq[11] == |(flag[P_CONVERTER] & enable[P_CONVERTER]))
        else $error("converter line does not follow enabled flags");

    serial_line_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag[P_SERIAL1][SERIAL_PARITY_BIT]
        && enable[P_SERIAL1][SERIAL_PARITY_BIT] |-> top_irq[5])
        else $error("serial 1 line low with enabled flag");

    late_enable_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        flag[P_TIMER2][TIMER_TRIGGER_BIT]
        && !enable[P_TIMER2][TIMER_TRIGGER_BIT]
        && wr_pending && wr_addr == slot(ENABLE_BASE, P_TIMER2)
        && hwdata[TIMER_TRIGGER_BIT] |=> top_irq[1])
        else $error("late enable did not raise timer 2 line");

    missed_set_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        periph_events.timer1[TIMER_UPDATE_BIT]
        && flag[P_TIMER1][TIMER_UPDATE_BIT]
        && enable[P_TIMER1][TIMER_UPDATE_BIT]
        && !conv_clr[0]
        && !(wr_pending && wr_addr == slot(FLAG_BASE, P_TIMER1))
        |=> missed[0])
        else $error("repeated event not marked missed");

    missed_clear_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pending && wr_addr == MISSED_OFS && hwdata[11] && !lost[11]
        |=> !missed[11])
        else $error("missed bit not cleared by write one");

    nmi_source_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(nmi) |-> $past(crystal_fail_evt) || $past(wdog_hit))
        else $error("nmi not tied to its two sources");

    crystal_fail_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        crystal_fail_evt |=> !system_clock_source && nmi
                             && nmi_flags[NMI_CRYSTAL_BIT])
        else $error("crystal failure not handled");

    wdog_fire_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wdog_hit |=> nmi && wdog_count == 32'h0000_0000)
        else $error("watchdog low water did not raise nmi");

    wrong_size_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        access_probe.valid && access_probe.is_apb
        && access_probe.size == 3'h0 |=> fault[FAULT_WIDTH_BIT] && bus_fault)
        else $error("byte access to peripheral not faulted");

    repeat_fault_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        access_probe.valid && access_probe.beyond_map && fault[2:0] != 3'h0
        |=> fault[FAULT_REPEAT_BIT])
        else $error("second fault did not set repeat bit");

    line_hold_c: cover property (
        @(posedge hclk) disable iff (!hresetn)
        top_irq[11] ##1 conv_clr != '0 ##1 !top_irq[11]);

    set_wins_c: cover property (
        @(posedge hclk) disable iff (!hresetn)
        conv_clr[0] && periph_events.converter[0]);

    wdog_c: cover property (
        @(posedge hclk) disable iff (!hresetn) wdog_hit);

    missed_c: cover property (
        @(posedge hclk) disable iff (!hresetn) lost != '0);

endmodule

`default_nettype wire

// ### tb/irq_top_model.sv
// Top-level interrupt controller model: one pend latch per line.
// Assumes the aggregator's level lines on the same clock.
`default_nettype none

module irq_top_model
    import event_aggregator_pkg::*;
(
    input  wire logic                 hclk,       // Clock.
    input  wire logic                 hresetn,    // Async reset.
    input  wire logic [NUM_LINES-1:0] lines,      // Level lines.
    input  wire logic [NUM_LINES-1:0] pend_clear, // Clear strobes.
    output logic      [NUM_LINES-1:0] pending     // Pended lines.
);
    timeunit 1ns;
    timeprecision 1ns;

    // A clear does not stick while the level line still stands.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~pend_clear) | lines;
        end
    end
endmodule

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the event aggregator.
// Assumes a zero wait state AHB-Lite slave on a 10 MHz hclk.
`default_nettype none

module tb
    import event_aggregator_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 hclk, hresetn, hwrite, hreadyout, hresp;
    logic                 nmi, bus_fault, src, crystal_lost, rd_phase;
    logic [31:0]          haddr, hwdata, hrdata, v;
    logic [1:0]           htrans;
    logic [NUM_LINES-1:0] top_irq, pend_clear, pending;
    periph_events_t       ev;
    access_probe_t        probe;
    logic [31:0]          exp_q[$];
    int                   err_count, total_checks, seed, s, i;
    logic [7:0]           fa, ea;

    event_aggregator #(.WDOG_LIMIT(16)) u_event_aggregator (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .periph_events(ev),
        .crystal_lost(crystal_lost), .access_probe(probe),
        .top_irq(top_irq), .nmi(nmi), .bus_fault(bus_fault),
        .system_clock_source(src));

    irq_top_model u_irq_top_model (
        .hclk(hclk), .hresetn(hresetn), .lines(top_irq),
        .pend_clear(pend_clear), .pending(pending));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One single transfer; a read notes its expected word for the monitor.
    task automatic bus(input logic [7:0] a, input logic wr,
                       input logic [31:0] d, input periph_events_t e);
        @(posedge hclk);
        haddr  <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans   <= 2'h0;
        hwdata   <= d;
        ev       <= e;
        rd_phase <= !wr;
        if (!wr) exp_q.push_back(d);
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        ev       <= '0;
        rd_phase <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, '0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b0, d, '0);
    endtask

    task automatic settle();
        @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic pulse(input periph_events_t e);
        @(posedge hclk);
        ev <= e;
        @(posedge hclk);
        ev <= '0;
        settle();
    endtask

    task automatic poke(input access_probe_t p, input logic f);
        @(posedge hclk);
        probe <= p;
        @(posedge hclk);
        probe <= '0;
        @(negedge hclk);
        check(bus_fault, f);
    endtask

    function automatic periph_events_t ev_of(input int sl,
                                             input logic [14:0] b);
        periph_events_t e;
        e = '0;
        case (sl)
            P_TIMER1:  e.timer1 = b[6:0];
            P_TIMER2:  e.timer2 = b[6:0];
            P_SERIAL1: e.serial1 = b;
            P_SERIAL2: e.serial2 = b[12:0];
            default:   e.converter = b[4:0];
        endcase
        return e;
    endfunction

    always @(posedge hclk) begin
        if (rd_phase && hreadyout) begin
            check(hrdata, exp_q.pop_front());
            check(hresp, 0);
        end
    end

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    initial begin
        #2_000_000;
        err_count++;
        give_verdict();
    end

    initial begin
        {hresetn, hwrite, crystal_lost, rd_phase} = '0;
        {haddr, hwdata, htrans, ev, probe, pend_clear} = '0;
        seed = 46;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check(top_irq, 0);
        check(src, 1);
        for (s = 0; s < 21; s++) begin
            rd(8'(4 * s), 32'(8'(4 * s) == CLOCK_OFS));
        end
        for (s = 0; s < NUM_PERIPH; s++) begin
            fa = FLAG_BASE + 8'(4 * s);
            ea = ENABLE_BASE + 8'(4 * s);
            v = ($random(seed) & VALID_MASK[s]) | 32'h1;
            pulse(ev_of(s, v[14:0]));
            check(top_irq, 0);
            rd(fa, v);
            wr(ea, v);
            settle();
            check(top_irq, 32'h1 << LINE_OF[s]);
            rd(ea, v);
            wr(fa, 0);
            rd(fa, v);
            pulse(ev_of(s, 15'h1));
            rd(MISSED_OFS, 32'h1 << LINE_OF[s]);
            wr(MISSED_OFS, 0);
            rd(MISSED_OFS, 32'h1 << LINE_OF[s]);
            wr(MISSED_OFS, 32'h1 << LINE_OF[s]);
            rd(MISSED_OFS, 0);
            bus(fa, 1'b1, 32'h1, ev_of(s, 15'h1));
            rd(fa, v);
            wr(fa, 1);
            settle();
            check(top_irq[LINE_OF[s]], v != 32'h1);
            pend_clear <= NUM_LINES'(1) << LINE_OF[s];
            @(posedge hclk);
            pend_clear <= '0;
            settle();
            check(pending[LINE_OF[s]], v != 32'h1);
            wr(fa, v);
            settle();
            check(top_irq, 0);
            wr(ea, 0);
            rd(ea, 0);
            check(nmi, 0);
        end
        rd(8'h3C, 0);
        poke('{1, 1, 0, 1, 0, 0, 3'h0, 2'h0}, 1'b1);
        rd(FAULT_OFS, 1);
        poke('{1, 0, 1, 0, 1, 1, 3'h2, 2'h0}, 1'b1);
        rd(FAULT_OFS, 32'hF);
        wr(FAULT_OFS, 32'hF);
        poke('{1, 1, 0, 1, 0, 0, 3'h2, 2'h1}, 1'b1);
        rd(FAULT_OFS, 1);
        wr(FAULT_OFS, 1);
        poke('{1, 1, 1, 1, 0, 0, 3'h2, 2'h0}, 1'b0);
        rd(FAULT_OFS, 0);
        @(posedge hclk);
        crystal_lost <= 1'b1;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        check(src, 0);
        check(nmi, 1);
        rd(NMI_OFS, 1);
        crystal_lost <= 1'b0;
        wr(NMI_OFS, 1);
        wr(CLOCK_OFS, 1);
        settle();
        check(src, 1);
        check(nmi, 0);
        repeat (3) begin
            wr(WDOG_OFS, 3);
            repeat (8) @(posedge hclk);
        end
        @(negedge hclk);
        check(nmi, 0);
        for (i = 0; i < 30 && nmi !== 1'b1; i++) @(negedge hclk);
        check(nmi, 1);
        rd(NMI_OFS, 2);
        wr(WDOG_OFS, 0);
        wr(NMI_OFS, 2);
        settle();
        check(nmi, 0);
        give_verdict();
    end
endmodule

`default_nettype wire
